/* File: hw/pfdx_pkg.sv */
package pfdx_pkg;

    // Vector offsets inside the exception area
    localparam logic [19:0] PFDX_VEC_EXT = 20'h00500;
    localparam logic [19:0] PFDX_VEC_PROG = 20'h00700;
    localparam logic [19:0] PFDX_VEC_FPU = 20'h00800;
    localparam logic [19:0] PFDX_VEC_DEC = 20'h00900;
    localparam int PFDX_VEC_W = 20;

    // Program cause bits in save_restore_reg_one
    localparam int PFDX_SAVE_RESTORE_REG_ONE_FPE = 20;
    localparam int PFDX_SAVE_RESTORE_REG_ONE_ILL = 19;
    localparam int PFDX_SAVE_RESTORE_REG_ONE_PRIV = 18;
    localparam int PFDX_SAVE_RESTORE_REG_ONE_TRAP = 17;

    // Register byte offsets
    localparam logic [7:0] PFDX_OFF_BASE = 8'h00;
    localparam logic [7:0] PFDX_OFF_STATUS = 8'h04;
    localparam logic [7:0] PFDX_OFF_MASK = 8'h08;
    localparam logic [7:0] PFDX_OFF_STATE = 8'h0c;

    // Reset values
    localparam logic [31:0] PFDX_BASE_RST = 32'h00000000;
    localparam logic [3:0] PFDX_MASK_RST = 4'h0;

    // Event bits of status and mask
    localparam int PFDX_EV_PROG = 0;
    localparam int PFDX_EV_FPU = 1;
    localparam int PFDX_EV_DEC = 2;
    localparam int PFDX_EV_EXT = 3;
    localparam int PFDX_EV_W = 4;

    // State readback fields
    localparam int PFDX_ST_FEX = 0;
    localparam int PFDX_ST_DECP = 1;
    localparam int PFDX_ST_KIND = 4;

    localparam logic [1:0] PFDX_RESP_OKAY = 2'h0;
    localparam logic [1:0] PFDX_RESP_SLVERR = 2'h2;
    localparam int PFDX_TRAP_W = 5;

endpackage

/* File: hw/pfdx_rst_sync.sv */
`timescale 1ns/100ps
module pfdx_rst_sync
    import pfdx_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    output logic rst_n_o
);
    typedef struct packed {
        logic [1:0] sync;
    } pfdx_sync_type;

    pfdx_sync_type s_reg;
    pfdx_sync_type s_next;

    always_comb begin
        s_next.sync = {s_reg.sync[0], 1'b1};
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rst_n_o = s_reg.sync[1];
endmodule

/* File: hw/pfdx_exc_unit.sv */
// Summary of operation
// - Program exceptions vector to offset 00700 for fp-enabled, illegal, privileged, trap.
// - A taken program exception records its causes in save_restore_reg_one.
// - Fp-enabled exception when summary flag set and either fp mode bit set.
// - Summary flag set when fp instruction raises an enabled exception condition.
// - Move-to-fp-status sets summary when a condition and its enable both set.
// - Illegal opcode or opcode combination raises illegal instruction exception.
// - Absent optional instructions are illegal unless treated as no-ops.
// - Privileged instruction in user mode raises privileged exception.
// - Special register move with invalid field, top bit one, user mode: privileged.
// - Trap exception when any encoded trap comparison is true.
// - Any fp instruction with fp unavailable vectors to offset 00800.
// - Decrementer msb rising zero to one signals exception at offset 00900.
// - Pending decrementer exception taken only while external irq enable set.
// - External interrupt taken only while external irq enable bit set.
`timescale 1ns/100ps
module pfdx_exc_unit
    import pfdx_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int NUM_FP_EXC = 5
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic instr_complete_i,
    input wire logic illegal_opcode_i,
    input wire logic optional_absent_i,
    input wire logic optional_as_nop_i,
    input wire logic privileged_i,
    input wire logic spr_move_i,
    input wire logic spr_field_invalid_i,
    input wire logic spr_field_top_i,
    input wire logic trap_instr_i,
    input wire logic [PFDX_TRAP_W-1:0] trap_select_i,
    input wire logic [PFDX_TRAP_W-1:0] trap_compare_i,
    input wire logic fp_instr_i,
    input wire logic [NUM_FP_EXC-1:0] fp_exc_cond_i,
    input wire logic [NUM_FP_EXC-1:0] fp_exc_enable_i,
    input wire logic fp_status_move_i,
    input wire logic [NUM_FP_EXC-1:0] fp_status_move_cond_i,
    input wire logic [NUM_FP_EXC-1:0] fp_status_move_enable_i,
    input wire logic fp_exc_mode_bit_a_i,
    input wire logic fp_exc_mode_bit_b_i,
    input wire logic user_privilege_bit_i,
    input wire logic fp_available_bit_i,
    input wire logic external_irq_enable_bit_i,
    input wire logic external_irq_i,
    input wire logic down_counter_msb_i,
    output logic exc_take_o,
    output logic [31:0] exc_vector_o,
    output logic [31:0] save_restore_reg_one_o,
    output logic fp_enabled_exc_summary_o,
    output logic dec_pending_o,
    output logic irq_o
);
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end
    if (NUM_FP_EXC < 1 || NUM_FP_EXC > 32) begin : g_bad_num_fp_exc
        $error("NUM_FP_EXC out of range");
    end
    typedef struct packed {
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] exc_base;
        logic [PFDX_EV_W-1:0] irq_status;
        logic [PFDX_EV_W-1:0] irq_mask;
        logic irq;
        logic fp_enabled_exc_summary;
        logic dec_msb_prev;
        logic dec_pending;
        logic take;
        logic [31:0] vector;
        logic [31:0] save_restore_reg_one;
        logic [PFDX_EV_W-1:0] last_kind;
    } pfdx_state_type;
    pfdx_state_type s_reg;
    pfdx_state_type s_next;
    logic rst_sync_n;
    logic fex_now, fp_unavail_c, fpe_c, illegal_c, priv_c, trap_c;
    logic prog_c, ext_c, dec_c, dec_edge_c;
    logic [PFDX_EV_W-1:0] events_c;

    pfdx_rst_sync u_rst_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .rst_n_o(rst_sync_n)
    );

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
        logic [7:0] a;
        a = 8'(addr);
        return (addr[1:0] == 2'h0) && (ADDR_W <= 8 || (addr >> 8) == '0) &&
               (a == PFDX_OFF_BASE || a == PFDX_OFF_STATUS ||
                a == PFDX_OFF_MASK || a == PFDX_OFF_STATE);
    endfunction

    function automatic logic [31:0] vec_addr(input logic [31:0] base,
                                             input logic [19:0] off);
        return {base[31:PFDX_VEC_W], off};
    endfunction

    always_comb begin
        // Summary flag as left by the completing instruction
        fex_now = s_reg.fp_enabled_exc_summary;
        if (instr_complete_i && fp_status_move_i) begin
            fex_now = |(fp_status_move_cond_i & fp_status_move_enable_i);
        end else if (instr_complete_i && fp_instr_i && fp_available_bit_i &&
                     |(fp_exc_cond_i & fp_exc_enable_i)) begin
            fex_now = 1'b1;
        end
        fp_unavail_c = instr_complete_i && fp_instr_i && !fp_available_bit_i;
        fpe_c = instr_complete_i && fex_now &&
                (fp_exc_mode_bit_a_i || fp_exc_mode_bit_b_i);
        illegal_c = instr_complete_i && (illegal_opcode_i ||
                    (optional_absent_i && !optional_as_nop_i));
        priv_c = instr_complete_i && user_privilege_bit_i && (privileged_i ||
                 (spr_move_i && spr_field_invalid_i && spr_field_top_i));
        trap_c = instr_complete_i && trap_instr_i &&
                 |(trap_select_i & trap_compare_i);
        prog_c = !fp_unavail_c && (fpe_c || illegal_c || priv_c || trap_c);
        ext_c = instr_complete_i && !fp_unavail_c && !prog_c &&
                external_irq_i && external_irq_enable_bit_i;
        dec_c = instr_complete_i && !fp_unavail_c && !prog_c && !ext_c &&
                s_reg.dec_pending && external_irq_enable_bit_i;
        dec_edge_c = down_counter_msb_i && !s_reg.dec_msb_prev;
        events_c = '0;
        events_c[PFDX_EV_PROG] = prog_c;
        events_c[PFDX_EV_FPU] = fp_unavail_c;
        events_c[PFDX_EV_DEC] = dec_c;
        events_c[PFDX_EV_EXT] = ext_c;
    end

    always_comb begin
        s_next = s_reg;
        s_next.take = 1'b0;
        // Write address and data are taken independently
        if (s_axi_awvalid_i && s_reg.awready) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_reg.wready) begin
            s_next.w_held = 1'b1;
            s_next.w_data = s_axi_wdata_i;
            s_next.w_strb = s_axi_wstrb_i;
        end
        if (s_reg.bvalid && s_axi_bready_i) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = reg_mapped(s_reg.aw_addr) ? PFDX_RESP_OKAY : PFDX_RESP_SLVERR;
            if (reg_mapped(s_reg.aw_addr)) begin
                unique case (8'(s_reg.aw_addr))
                    PFDX_OFF_BASE: begin
                        s_next.exc_base = merge_bytes(s_reg.exc_base, s_reg.w_data,
                                                      s_reg.w_strb);
                        s_next.exc_base[PFDX_VEC_W-1:0] = '0;
                    end
                    PFDX_OFF_STATUS: begin
                        if (s_reg.w_strb[0]) begin
                            s_next.irq_status = s_reg.irq_status &
                                                ~s_reg.w_data[PFDX_EV_W-1:0];
                        end
                    end
                    PFDX_OFF_MASK: begin
                        if (s_reg.w_strb[0]) begin
                            s_next.irq_mask = s_reg.w_data[PFDX_EV_W-1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready = !s_next.w_held && !s_next.bvalid;

        // Read channel: one read at a time
        if (s_axi_arvalid_i && s_reg.arready) begin
            s_next.arready = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rdata = '0;
            s_next.rresp = reg_mapped(s_axi_araddr_i) ? PFDX_RESP_OKAY : PFDX_RESP_SLVERR;
            if (reg_mapped(s_axi_araddr_i)) begin
                unique case (8'(s_axi_araddr_i))
                    PFDX_OFF_BASE: s_next.rdata = s_reg.exc_base;
                    PFDX_OFF_STATUS: s_next.rdata[PFDX_EV_W-1:0] = s_reg.irq_status;
                    PFDX_OFF_MASK: s_next.rdata[PFDX_EV_W-1:0] = s_reg.irq_mask;
                    PFDX_OFF_STATE: begin
                        s_next.rdata[PFDX_ST_FEX] = s_reg.fp_enabled_exc_summary;
                        s_next.rdata[PFDX_ST_DECP] = s_reg.dec_pending;
                        s_next.rdata[PFDX_ST_KIND +: PFDX_EV_W] = s_reg.last_kind;
                    end
                    default: begin
                    end
                endcase
            end
        end else if (s_reg.rvalid && s_axi_rready_i) begin
            s_next.rvalid = 1'b0;
            s_next.arready = 1'b1;
        end
        // Address accepted whenever no read data is waiting; reset clears arready until the first clock after it
        s_next.arready = !s_next.rvalid;

        // Exception state
        s_next.fp_enabled_exc_summary = fex_now;
        s_next.dec_msb_prev = down_counter_msb_i;
        if (dec_c) begin
            s_next.dec_pending = 1'b0;
        end
        if (dec_edge_c) begin
            s_next.dec_pending = 1'b1;
        end
        if (|events_c) begin
            s_next.take = 1'b1;
            s_next.last_kind = events_c;
            s_next.save_restore_reg_one = '0;
        end
        if (fp_unavail_c) begin
            s_next.vector = vec_addr(s_reg.exc_base, PFDX_VEC_FPU);
        end else if (prog_c) begin
            s_next.vector = vec_addr(s_reg.exc_base, PFDX_VEC_PROG);
            s_next.save_restore_reg_one[PFDX_SAVE_RESTORE_REG_ONE_FPE] = fpe_c;
            s_next.save_restore_reg_one[PFDX_SAVE_RESTORE_REG_ONE_ILL] = illegal_c;
            s_next.save_restore_reg_one[PFDX_SAVE_RESTORE_REG_ONE_PRIV] = priv_c;
            s_next.save_restore_reg_one[PFDX_SAVE_RESTORE_REG_ONE_TRAP] = trap_c;
        end else if (ext_c) begin
            s_next.vector = vec_addr(s_reg.exc_base, PFDX_VEC_EXT);
        end else if (dec_c) begin
            s_next.vector = vec_addr(s_reg.exc_base, PFDX_VEC_DEC);
        end
        // New events win over a same-cycle clear
        s_next.irq_status = s_next.irq_status | events_c;
        s_next.irq = |(s_next.irq_status & s_next.irq_mask);
    end

    always_ff @(posedge clock_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_reg <= '0;
            s_reg.exc_base <= PFDX_BASE_RST;
            s_reg.irq_mask <= PFDX_MASK_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready_o = s_reg.awready;
    assign s_axi_wready_o = s_reg.wready;
    assign s_axi_bvalid_o = s_reg.bvalid;
    assign s_axi_bresp_o = s_reg.bresp;
    assign s_axi_arready_o = s_reg.arready;
    assign s_axi_rvalid_o = s_reg.rvalid;
    assign s_axi_rdata_o = s_reg.rdata;
    assign s_axi_rresp_o = s_reg.rresp;
    assign exc_take_o = s_reg.take;
    assign exc_vector_o = s_reg.vector;
    assign save_restore_reg_one_o = s_reg.save_restore_reg_one;
    assign fp_enabled_exc_summary_o = s_reg.fp_enabled_exc_summary;
    assign dec_pending_o = s_reg.dec_pending;
    assign irq_o = s_reg.irq;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_sync_n);
    property p_prog_vector;
        instr_complete_i && illegal_opcode_i && !(fp_instr_i && !fp_available_bit_i)
        |=> exc_take_o && exc_vector_o[19:0] == PFDX_VEC_PROG;
    endproperty
    a_prog_vector: assert property (p_prog_vector) else $error("program vector wrong");

    property p_save_restore_reg_one_trap;
        instr_complete_i && trap_instr_i && |(trap_select_i & trap_compare_i) &&
        !(fp_instr_i && !fp_available_bit_i)
        |=> save_restore_reg_one_o[PFDX_SAVE_RESTORE_REG_ONE_TRAP] && exc_vector_o[19:0] == PFDX_VEC_PROG;
    endproperty
    a_save_restore_reg_one_trap: assert property (p_save_restore_reg_one_trap) else $error("trap cause not recorded");

    property p_fpe;
        instr_complete_i && fex_now && (fp_exc_mode_bit_a_i || fp_exc_mode_bit_b_i) &&
        !(fp_instr_i && !fp_available_bit_i)
        |=> exc_take_o && save_restore_reg_one_o[PFDX_SAVE_RESTORE_REG_ONE_FPE];
    endproperty
    a_fpe: assert property (p_fpe) else $error("fp enabled exception missed");

    property p_fex_set;
        instr_complete_i && fp_instr_i && fp_available_bit_i && !fp_status_move_i &&
        |(fp_exc_cond_i & fp_exc_enable_i) |=> fp_enabled_exc_summary_o;
    endproperty
    a_fex_set: assert property (p_fex_set) else $error("summary flag not set");

    property p_fex_move;
        instr_complete_i && fp_status_move_i
        |=> fp_enabled_exc_summary_o ==
            $past(|(fp_status_move_cond_i & fp_status_move_enable_i));
    endproperty
    a_fex_move: assert property (p_fex_move) else $error("summary after move wrong");

    property p_priv;
        instr_complete_i && user_privilege_bit_i && privileged_i &&
        !(fp_instr_i && !fp_available_bit_i) |=> save_restore_reg_one_o[PFDX_SAVE_RESTORE_REG_ONE_PRIV];
    endproperty
    a_priv: assert property (p_priv) else $error("privileged cause missed");

    property p_fpu_vector;
        instr_complete_i && fp_instr_i && !fp_available_bit_i
        |=> exc_take_o && exc_vector_o == {$past(s_reg.exc_base[31:20]), PFDX_VEC_FPU};
    endproperty
    a_fpu_vector: assert property (p_fpu_vector) else $error("fp unavailable vector");

    property p_dec_edge;
        $rose(down_counter_msb_i) |=> dec_pending_o;
    endproperty
    a_dec_edge: assert property (p_dec_edge) else $error("decrementer edge lost");

    property p_dec_hold;
        !external_irq_enable_bit_i
        |=> !(exc_take_o && exc_vector_o[19:0] == PFDX_VEC_DEC) &&
            !(exc_take_o && exc_vector_o[19:0] == PFDX_VEC_EXT);
    endproperty
    a_dec_hold: assert property (p_dec_hold) else $error("async taken while disabled");

    property p_one_per_instr;
        exc_take_o |-> $past(instr_complete_i) && $onehot(s_reg.last_kind);
    endproperty
    a_one_per_instr: assert property (p_one_per_instr) else $error("take without completion");
endmodule

/* File: verification/pfdx_pipe_model.sv */
`timescale 1ns/100ps
module pfdx_pipe_model
    import pfdx_pkg::*;
(
    input wire logic clock_i,
    output logic complete_o,
    output logic [9:0] qual_o,
    output logic [PFDX_TRAP_W-1:0] trap_sel_o,
    output logic [PFDX_TRAP_W-1:0] trap_cmp_o,
    output logic [4:0] fp_cond_o,
    output logic [4:0] fp_en_o
);
    integer seed = 32'h2b6b;

    // Qualifiers carry noise between completions
    task automatic junk();
        qual_o <= 10'($random(seed));
        trap_sel_o <= 5'($random(seed));
        trap_cmp_o <= 5'($random(seed));
        fp_cond_o <= 5'($random(seed));
        fp_en_o <= 5'($random(seed));
    endtask

    task automatic issue(input logic [9:0] q, input logic [4:0] ts, input logic [4:0] tc,
                         input logic [4:0] fc, input logic [4:0] fe);
        @(posedge clock_i);
        complete_o <= 1'b1;
        qual_o <= q;
        trap_sel_o <= ts;
        trap_cmp_o <= tc;
        fp_cond_o <= fc;
        fp_en_o <= fe;
        @(posedge clock_i);
        complete_o <= 1'b0;
        junk();
    endtask

    initial begin
        complete_o <= 1'b0;
        junk();
    end
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top
    import pfdx_pkg::*;
();
    localparam logic [9:0] Q_ILL = 10'h001, Q_OABS = 10'h002, Q_ONOP = 10'h004;
    localparam logic [9:0] Q_PRIV = 10'h008, Q_SPR = 10'h010, Q_SPRI = 10'h020;
    localparam logic [9:0] Q_SPRT = 10'h040, Q_TRAP = 10'h080, Q_FP = 10'h100, Q_FSM = 10'h200;
    localparam logic [31:0] C_FPE = 32'h1 << PFDX_SAVE_RESTORE_REG_ONE_FPE, C_ILL = 32'h1 << PFDX_SAVE_RESTORE_REG_ONE_ILL;
    localparam logic [31:0] C_PRIV = 32'h1 << PFDX_SAVE_RESTORE_REG_ONE_PRIV, C_TRAP = 32'h1 << PFDX_SAVE_RESTORE_REG_ONE_TRAP;
    logic clock = 1'b0, rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic mode_a = 1'b0, mode_b = 1'b0, user = 1'b0, fpav = 1'b1, ee = 1'b0;
    logic ext = 1'b0, msb = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, take, fsum, decp, irq, comp;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, vec, save_restore_reg_one, base_exp = 32'h0;
    logic [9:0] qual;
    logic [4:0] tsel, tcmp, fcond, fen, ts, tc;
    logic [63:0] e;
    logic [63:0] expq[$];
    integer seed = 32'h2b6b;
    int mismatches = 0, cmp_count = 0;

    always #2 clock = ~clock;

    pfdx_pipe_model u_pipe (.clock_i(clock), .complete_o(comp), .qual_o(qual),
        .trap_sel_o(tsel), .trap_cmp_o(tcmp), .fp_cond_o(fcond), .fp_en_o(fen));

    pfdx_exc_unit u_dut (.clock_i(clock), .rst_n_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .instr_complete_i(comp),
        .illegal_opcode_i(qual[0]), .optional_absent_i(qual[1]), .optional_as_nop_i(qual[2]),
        .privileged_i(qual[3]), .spr_move_i(qual[4]), .spr_field_invalid_i(qual[5]),
        .spr_field_top_i(qual[6]), .trap_instr_i(qual[7]), .trap_select_i(tsel),
        .trap_compare_i(tcmp), .fp_instr_i(qual[8]), .fp_exc_cond_i(fcond),
        .fp_exc_enable_i(fen), .fp_status_move_i(qual[9]), .fp_status_move_cond_i(fcond),
        .fp_status_move_enable_i(fen), .fp_exc_mode_bit_a_i(mode_a),
        .fp_exc_mode_bit_b_i(mode_b), .user_privilege_bit_i(user),
        .fp_available_bit_i(fpav), .external_irq_enable_bit_i(ee), .external_irq_i(ext),
        .down_counter_msb_i(msb), .exc_take_o(take), .exc_vector_o(vec),
        .save_restore_reg_one_o(save_restore_reg_one), .fp_enabled_exc_summary_o(fsum),
        .dec_pending_o(decp), .irq_o(irq));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        logic ad = 1'b0;
        logic wd = 1'b0;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd) && n < 100) begin
            @(posedge clock);
            n++;
            if (!ad && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        chk(32'(n < 100), 32'h1);
        chk(32'(bresp), 32'(r));
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                            input logic [1:0] r);
        int n = 0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (arready !== 1'b1 && n < 100);
        arvalid <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (rvalid !== 1'b1 && n < 100);
        chk(32'(n < 100), 32'h1);
        chk(rdata & m, x);
        chk(32'(rresp), 32'(r));
        rready <= 1'b0;
    endtask

    task automatic ex(input logic [19:0] off, input logic [31:0] s);
        expq.push_back({base_exp[31:20], off, s});
    endtask

    task automatic go(input logic [9:0] q);
        u_pipe.issue(q, 5'h00, 5'h00, 5'h00, 5'h00);
    endtask

    always @(posedge clock) begin
        if (take === 1'b1) begin
            if (expq.size() == 0) begin
                mismatches++;
                $display("[ERR] %0t unexpected exception taken", $time);
            end else begin
                e = expq.pop_front();
                chk(vec, e[63:32]);
                chk(save_restore_reg_one, e[31:0]);
            end
        end
    end

    initial begin
        #80000;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        axi_write(PFDX_OFF_BASE, 32'habcde123, PFDX_RESP_OKAY);
        base_exp = 32'habc00000;
        axi_read(PFDX_OFF_BASE, 32'hffffffff, 32'habc00000, PFDX_RESP_OKAY);
        axi_write(PFDX_OFF_MASK, 32'h1, PFDX_RESP_OKAY);
        axi_read(8'h10, 32'hffffffff, 32'h0, PFDX_RESP_SLVERR);
        axi_write(8'h10, 32'hffffffff, PFDX_RESP_SLVERR);
        ex(PFDX_VEC_PROG, C_ILL);
        go(Q_ILL);
        repeat (3) @(posedge clock);
        chk(32'(irq), 32'h1);
        axi_write(PFDX_OFF_STATUS, 32'h1, PFDX_RESP_OKAY);
        repeat (3) @(posedge clock);
        chk(32'(irq), 32'h0);
        ex(PFDX_VEC_PROG, C_ILL);
        go(Q_OABS);
        go(Q_OABS | Q_ONOP);
        user <= 1'b1;
        ex(PFDX_VEC_PROG, C_PRIV);
        go(Q_PRIV);
        ex(PFDX_VEC_PROG, C_PRIV);
        go(Q_SPR | Q_SPRI | Q_SPRT);
        ex(PFDX_VEC_PROG, C_ILL | C_PRIV | C_TRAP);
        u_pipe.issue(Q_ILL | Q_PRIV | Q_TRAP, 5'h01, 5'h01, 5'h00, 5'h00);
        user <= 1'b0;
        go(Q_PRIV);
        for (int i = 0; i < 5; i++) begin
            ex(PFDX_VEC_PROG, C_TRAP);
            u_pipe.issue(Q_TRAP, 5'h01 << i, 5'h01 << i, 5'h00, 5'h00);
            u_pipe.issue(Q_TRAP, 5'h01 << i, ~(5'h01 << i), 5'h00, 5'h00);
        end
        repeat (8) begin
            ts = 5'($random(seed));
            tc = 5'($random(seed));
            if (|(ts & tc)) ex(PFDX_VEC_PROG, C_TRAP);
            u_pipe.issue(Q_TRAP, ts, tc, 5'h00, 5'h00);
        end
        fpav <= 1'b0;
        ex(PFDX_VEC_FPU, 32'h0);
        u_pipe.issue(Q_FP | Q_ILL, 5'h00, 5'h00, 5'h01, 5'h01);
        fpav <= 1'b1;
        mode_a <= 1'b1;
        ex(PFDX_VEC_PROG, C_FPE);
        u_pipe.issue(Q_FP, 5'h00, 5'h00, 5'h01, 5'h01);
        u_pipe.issue(Q_FSM, 5'h00, 5'h00, 5'h04, 5'h00);
        mode_a <= 1'b0;
        mode_b <= 1'b1;
        ex(PFDX_VEC_PROG, C_FPE);
        u_pipe.issue(Q_FSM, 5'h00, 5'h00, 5'h04, 5'h04);
        axi_read(PFDX_OFF_STATE, 32'h1, 32'h1, PFDX_RESP_OKAY);
        chk(32'(fsum), 32'h1);
        mode_b <= 1'b0;
        go(10'h000);
        u_pipe.issue(Q_FSM, 5'h00, 5'h00, 5'h1f, 5'h00);
        msb <= 1'b1;
        go(10'h000);
        axi_read(PFDX_OFF_STATE, 32'h2, 32'h2, PFDX_RESP_OKAY);
        chk(32'(decp), 32'h1);
        chk(32'(fsum), 32'h0);
        ee <= 1'b1;
        ex(PFDX_VEC_DEC, 32'h0);
        go(10'h000);
        ee <= 1'b0;
        msb <= 1'b0;
        ext <= 1'b1;
        go(10'h000);
        ee <= 1'b1;
        ex(PFDX_VEC_EXT, 32'h0);
        go(10'h000);
        ext <= 1'b0;
        ee <= 1'b0;
        axi_read(PFDX_OFF_STATUS, 32'hf, 32'hf, PFDX_RESP_OKAY);
        repeat (5) @(posedge clock);
        chk(32'(expq.size()), 32'h0);
        summarize();
    end
endmodule
